// file: src/dsc_dual_dac_port.sv
`timescale 1ns/1ps
// Summary of operation
// - Bits shift in only while the select line is low.
// - Rising select line ends the frame and runs the command if at least 24 bits came in.
// - Data sampled on rising serial clock edges only.
// - Word is taken from the last 24 rising edges before select rises.
// - Frames of 24 or 32 bits accepted; 8 leading bits ignored.
// - Command, then address, then 16-bit data, each MSB first.
// - Address 0 is A, 1 is B, F both; others reserved.
// - Data is left-justified; all 16 bits kept.
// - Command 0 writes input register only.
// - Command 1 copies input to converter register and powers up.
// - Command 2 writes input then updates and powers up all channels.
// - Command 3 writes and updates the addressed channel.
// - Host also sends reserved commands (command 5); reserved ones do nothing.
// - Write moves the 16-bit data word into the input register.
// - Update copies input register to the active converter code.
// - Update clears the channel's power-down state.
// - Reset gives zero converter codes on both channels.
// - Power-down ignores data and only powers channels down.
// - Powered-down channels keep register contents.
module dsc_dual_dac_port
	import dsc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic selectLoadN,
	input wire logic serialClock,
	input wire logic serialData,
	output logic [15:0] codeA,
	output logic [15:0] codeB,
	output logic powerDownA,
	output logic powerDownB
);
	dsc_word_if word();
	logic [15:0] inputA;
	logic [15:0] inputB;
	logic selA;
	logic selB;
	logic doWrite;
	logic updAddr;
	logic updAll;
	logic doPowerDown;
	logic next_updA;
	logic next_updB;

	dsc_serial_link link (
		.clk(clk),
		.rst(rst),
		.selectLoadN(selectLoadN),
		.serialClock(serialClock),
		.serialData(serialData),
		.word(word)
	);

	// Channel decode
	always_comb begin
		selA = 1'b0;
		selB = 1'b0;
		case (word.channelAddressField)
			ADDR_CH_A: selA = 1'b1;
			ADDR_CH_B: selB = 1'b1;
			ADDR_ALL: begin
				selA = 1'b1;
				selB = 1'b1;
			end
			default: begin
				selA = 1'b0;
				selB = 1'b0;
			end
		endcase
	end

	// Command decode; reserved and no-op codes leave everything alone
	always_comb begin
		doWrite = 1'b0;
		updAddr = 1'b0;
		updAll = 1'b0;
		doPowerDown = 1'b0;
		case (word.commandField)
			CMD_WRITE: doWrite = 1'b1;
			CMD_UPDATE: updAddr = 1'b1;
			CMD_WRITE_UPDATE_ALL: begin
				doWrite = 1'b1;
				updAll = 1'b1;
			end
			CMD_WRITE_UPDATE: begin
				doWrite = 1'b1;
				updAddr = 1'b1;
			end
			CMD_POWER_DOWN: doPowerDown = 1'b1;
			default: doWrite = 1'b0;
		endcase
	end

	assign next_updA = word.execute & (updAll | (updAddr & selA));
	assign next_updB = word.execute & (updAll | (updAddr & selB));

	// Input registers
	always_ff @(posedge clk) begin
		if (rst) begin
			inputA <= CODE_RESET;
			inputB <= CODE_RESET;
		end else if (word.execute && doWrite) begin
			if (selA) inputA <= word.dataWord;
			if (selB) inputB <= word.dataWord;
		end
	end

	// Converter registers; a write-and-update takes the new word at once
	always_ff @(posedge clk) begin
		if (rst) begin
			codeA <= CODE_RESET;
			codeB <= CODE_RESET;
		end else begin
			if (next_updA) codeA <= (doWrite && selA) ? word.dataWord : inputA;
			if (next_updB) codeB <= (doWrite && selB) ? word.dataWord : inputB;
		end
	end

	// Power-down flags; setting a flag leaves the registers untouched
	always_ff @(posedge clk) begin
		if (rst) begin
			powerDownA <= 1'b0;
			powerDownB <= 1'b0;
		end else if (word.execute) begin
			if (doPowerDown && selA) powerDownA <= 1'b1;
			else if (next_updA) powerDownA <= 1'b0;
			if (doPowerDown && selB) powerDownB <= 1'b1;
			else if (next_updB) powerDownB <= 1'b0;
		end
	end
endmodule // dsc_dual_dac_port

// file: src/dsc_pkg.sv
package dsc_pkg;
	// Word layout
	localparam int WORD_BITS = 24;
	localparam int CMD_MSB = 23;
	localparam int CMD_LSB = 20;
	localparam int ADDR_MSB = 19;
	localparam int ADDR_LSB = 16;
	localparam int DATA_MSB = 15;
	localparam int DATA_BITS = 16;
	// Reset values
	localparam logic [15:0] CODE_RESET = 16'h0000;
	localparam logic [23:0] SHIFT_RESET = 24'h000000;
	// Command codes
	localparam logic [3:0] CMD_WRITE = 4'h0;
	localparam logic [3:0] CMD_UPDATE = 4'h1;
	localparam logic [3:0] CMD_WRITE_UPDATE_ALL = 4'h2;
	localparam logic [3:0] CMD_WRITE_UPDATE = 4'h3;
	localparam logic [3:0] CMD_POWER_DOWN = 4'h4;
	localparam logic [3:0] CMD_NOP = 4'hf;
	// Channel address codes
	localparam logic [3:0] ADDR_CH_A = 4'h0;
	localparam logic [3:0] ADDR_CH_B = 4'h1;
	localparam logic [3:0] ADDR_ALL = 4'hf;
	// Link states, Gray coded
	typedef enum logic [1:0] {
		LINK_IDLE = 2'b00,
		LINK_SHIFT = 2'b01,
		LINK_EXEC = 2'b11
	} dsc_link_t;
endpackage

// file: src/dsc_word_if.sv
`timescale 1ns/1ps
// Decoded word handed from the link to the register logic
interface dsc_word_if;
	logic execute;
	logic [3:0] commandField;
	logic [3:0] channelAddressField;
	logic [15:0] dataWord;
	modport link (output execute, output commandField, output channelAddressField,
		output dataWord);
	modport regs (input execute, input commandField, input channelAddressField,
		input dataWord);
endinterface

// file: src/dsc_serial_link.sv
`timescale 1ns/1ps
module dsc_serial_link
	import dsc_pkg::*;
(
	input wire logic clk,
	input wire logic rst,
	input wire logic selectLoadN,
	input wire logic serialClock,
	input wire logic serialData,
	dsc_word_if.link word
);
	logic [2:0] selSync;
	logic [2:0] sckSync;
	logic [1:0] sdiSync;
	logic [23:0] shiftReg;
	logic [5:0] bitCount;
	dsc_link_t state;
	logic sckRise;
	logic selRise;
	logic selLow;

	// Two-flop synchronisers plus one delay stage for edge finding
	always_ff @(posedge clk) begin
		if (rst) begin
			selSync <= 3'h7;
			sckSync <= 3'h0;
			sdiSync <= 2'h0;
		end else begin
			selSync <= {selSync[1:0], selectLoadN};
			sckSync <= {sckSync[1:0], serialClock};
			sdiSync <= {sdiSync[0], serialData};
		end
	end

	assign selLow = ~selSync[1];
	assign sckRise = sckSync[1] & ~sckSync[2];
	assign selRise = selSync[1] & ~selSync[2];

	// Frame state
	always_ff @(posedge clk) begin
		if (rst) begin
			state <= LINK_IDLE;
		end else begin
			case (state)
				LINK_IDLE: if (selLow) state <= LINK_SHIFT;
				LINK_SHIFT: if (selRise) state <= LINK_EXEC;
				LINK_EXEC: state <= LINK_IDLE;
				default: state <= LINK_IDLE;
			endcase
		end
	end

	// Shift in while selected; the last 24 bits stay, earlier padding falls off
	always_ff @(posedge clk) begin
		if (rst) begin
			shiftReg <= SHIFT_RESET;
			bitCount <= 6'h00;
		end else if (state == LINK_IDLE) begin
			bitCount <= 6'h00;
		end else if (selLow && sckRise) begin
			shiftReg <= {shiftReg[22:0], sdiSync[1]};
			if (bitCount != 6'h3f) bitCount <= bitCount + 6'h01;
		end
	end

	// Word outputs; short frames are dropped, 24 or more accepted
	always_ff @(posedge clk) begin
		if (rst) begin
			word.execute <= 1'b0;
			word.commandField <= CMD_NOP;
			word.channelAddressField <= ADDR_CH_A;
			word.dataWord <= CODE_RESET;
		end else begin
			word.execute <= 1'b0;
			if (state == LINK_SHIFT && selRise && bitCount >= 6'(WORD_BITS)) begin
				word.execute <= 1'b1;
				word.commandField <= shiftReg[CMD_MSB:CMD_LSB];
				word.channelAddressField <= shiftReg[ADDR_MSB:ADDR_LSB];
				word.dataWord <= shiftReg[DATA_MSB:0];
			end
		end
	end
endmodule // dsc_serial_link

// file: test/dsc_monitor.sv
`timescale 1ns/1ps
module dsc_monitor (
	input wire logic clk,
	input wire logic rst,
	input wire logic selectLoadN,
	input wire logic serialClock,
	input wire logic serialData,
	input wire logic [15:0] codeA,
	input wire logic [15:0] codeB,
	input wire logic powerDownA,
	input wire logic powerDownB
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);
	// Reset, frame timing, power flags
	a_reset_clears: assert property (disable iff (1'b0) rst |=>
		codeA == 16'h0000 && codeB == 16'h0000 && !powerDownA && !powerDownB) else $error("rst");
	a_frame_quiet: assert property (!selectLoadN [*8] |-> $stable(codeA) && $stable(codeB))
		else $error("frame");
	a_load_a_time: assert property ($changed(codeA) |-> $past(selectLoadN, 3))
		else $error("loadA");
	a_load_b_time: assert property ($changed(codeB) |-> $past(selectLoadN, 3))
		else $error("loadB");
	a_pd_keeps_a: assert property ($rose(powerDownA) |-> $stable(codeA) && $stable(codeB))
		else $error("pdA");
	a_pd_keeps_b: assert property ($rose(powerDownB) |-> $stable(codeA) && $stable(codeB))
		else $error("pdB");
	a_update_wakes_a: assert property ($changed(codeA) |-> !powerDownA)
		else $error("wakeA");
	a_update_wakes_b: assert property ($changed(codeB) |-> !powerDownB)
		else $error("wakeB");
	cover property ($rose(powerDownA));
	cover property ($fell(powerDownB));
	cover property ($changed(codeB));
endmodule // dsc_monitor
bind dsc_dual_dac_port dsc_monitor dsc_monitor_inst (.clk(clk), .rst(rst),
	.selectLoadN(selectLoadN), .serialClock(serialClock), .serialData(serialData),
	.codeA(codeA), .codeB(codeB), .powerDownA(powerDownA), .powerDownB(powerDownB));

// file: test/dsc_host.sv
`timescale 1ns/1ps
module dsc_host (
	input wire logic clk,
	output logic selectLoadN,
	output logic serialClock,
	output logic serialData
);
	// Idle link
	initial begin
		selectLoadN = 1'b1;
		serialClock = 1'b0;
		serialData = 1'b0;
	end
	// Just after a clock edge
	task automatic tick(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	// Frame of n bits, MSB first, 800 ns serial clock
	task automatic send(input logic [31:0] w, input int n, input logic en);
		tick(1);
		selectLoadN = !en;
		for (int i = n - 1; i >= 0; i--) begin
			serialData = w[i];
			tick(4);
			serialClock = 1'b1;
			tick(4);
			serialClock = 1'b0;
		end
		serialData = !serialData;
		tick(2);
		selectLoadN = 1'b1;
	endtask
endmodule // dsc_host

// file: test/test_dual_dac_serial_command_port.sv
`timescale 1ns/1ps
module test_dual_dac_serial_command_port import dsc_pkg::*;;
	logic clk, rst, selectLoadN, serialClock, serialData, powerDownA, powerDownB;
	logic [15:0] codeA, codeB;
	int err_count = 0;
	int checks_done = 0;
	dsc_dual_dac_port dsc_dual_dac_port_inst (.clk(clk), .rst(rst), .selectLoadN(selectLoadN),
		.serialClock(serialClock), .serialData(serialData), .codeA(codeA), .codeB(codeB),
		.powerDownA(powerDownA), .powerDownB(powerDownB));
	dsc_host dsc_host_inst (.clk(clk), .selectLoadN(selectLoadN), .serialClock(serialClock),
		.serialData(serialData));
	// Clock
	initial begin
		clk = 1'b0;
		forever #50 clk = ~clk;
	end
	task automatic check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
		checks_done++;
		if (seen !== exp) begin
			err_count++;
			$display("Error %s expected %h seen %h", nm, exp, seen);
		end
	endtask
	// Frame, settle, compare all outputs
	task automatic run(input logic [31:0] w, input int n, input logic en,
		input logic [15:0] eA, input logic [15:0] eB, input logic [1:0] eP);
		dsc_host_inst.send(w, n, en);
		repeat (6) @(posedge clk);
		#1;
		check("codeA", codeA, eA);
		check("codeB", codeB, eB);
		check("powerDown", {14'h0000, powerDownA, powerDownB}, {14'h0000, eP});
	endtask
	task automatic t_write;
		check("codeA", codeA, 16'h0000);
		check("codeB", codeB, 16'h0000);
		check("powerDown", {14'h0000, powerDownA, powerDownB}, 16'h0000);
		run(32'h00001234, 24, 1'b1, 16'h0000, 16'h0000, 2'b00);
		run(32'h0010ffff, 24, 1'b1, 16'h1234, 16'h0000, 2'b00);
		$display("write test done");
	endtask
	task automatic t_all;
		run(32'h0021abcd, 24, 1'b1, 16'h1234, 16'habcd, 2'b00);
		run(32'h003f5555, 24, 1'b1, 16'h5555, 16'h5555, 2'b00);
		$display("update test done");
	endtask
	task automatic t_pd;
		run(32'h0040ffff, 24, 1'b1, 16'h5555, 16'h5555, 2'b10);
		run(32'h004f0000, 24, 1'b1, 16'h5555, 16'h5555, 2'b11);
		run(32'h00100000, 24, 1'b1, 16'h5555, 16'h5555, 2'b01);
		run(32'h00310f0f, 24, 1'b1, 16'h5555, 16'h0f0f, 2'b00);
		$display("power test done");
	endtask
	task automatic t_frame;
		run(32'hff300001, 32, 1'b1, 16'h0001, 16'h0f0f, 2'b00);
		run(32'h00000777, 20, 1'b1, 16'h0001, 16'h0f0f, 2'b00);
		run(32'h0030aaaa, 24, 1'b0, 16'h0001, 16'h0f0f, 2'b00);
		run(32'h0032bbbb, 24, 1'b1, 16'h0001, 16'h0f0f, 2'b00);
		run(32'h0050cccc, 24, 1'b1, 16'h0001, 16'h0f0f, 2'b00);
		run(32'h00f0dddd, 24, 1'b1, 16'h0001, 16'h0f0f, 2'b00);
		$display("frame test done");
	endtask
	// Mid-run reset with both channels down, then a fresh frame
	task automatic t_reset;
		run(32'h004f0000, 24, 1'b1, 16'h0001, 16'h0f0f, 2'b11);
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		check("codeA", codeA, 16'h0000);
		check("codeB", codeB, 16'h0000);
		check("powerDown", {14'h0000, powerDownA, powerDownB}, 16'h0000);
		run(32'h00301111, 24, 1'b1, 16'h1111, 16'h0000, 2'b00);
		$display("reset test done");
	endtask
	task automatic test_done;
		$display("Checks %0d errors %0d", checks_done, err_count);
		if (err_count == 0 && checks_done > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask
	// Main sequence
	initial begin
		rst = 1'b1;
		repeat (12) @(posedge clk);
		#1 rst = 1'b0;
		t_write;
		t_all;
		t_pd;
		t_frame;
		t_reset;
		test_done;
	end
	// Hang guard
	initial begin
		repeat (20000) @(posedge clk);
		err_count++;
		test_done;
	end
endmodule // test_dual_dac_serial_command_port
